// ---- break_and_monitor_entry.sv ----
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module break_and_monitor_entry
  import brk_mon_pkg::*;
(
  input  wire logic                    clk,                // Bus clock
  input  wire logic                    sys_rst,            // Sync reset, high
  input  wire brk_mon_pkg::reg_req_t   reg_req,            // Register request
  output logic [7:0]                   reg_rdata,          // Read data, next cycle
  input  wire brk_mon_pkg::cpu_bus_t   cpu_bus,            // CPU address/status
  output logic                         breakpoint_request, // Break pulse
  output logic                         opcode_suppress,    // Block opcode execution
  output logic                         break_state,        // Handler in progress
  output logic [15:0]                  break_vector,       // Vector to use
  output logic                         status_clear_allowed, // Status clears permitted
  input  wire brk_mon_pkg::entry_pins_t entry_pins,        // Levels at reset
  input  wire logic                    monitor_serial_pin_in,  // Serial pin level
  output logic                         monitor_serial_pin_out, // Always low
  output logic                         monitor_serial_pin_oe,  // Pull low
  output logic                         monitor_mode,       // Monitor latched
  output logic                         forced_monitor,     // Forced entry taken
  output logic [7:0]                   security_byte,      // Received byte
  output logic                         security_byte_valid, // Byte strobe
  output logic                         monitor_ready       // Break sent
);
  import brk_mon_pkg::*;

  logic [7:0]  break_address_high;
  logic [7:0]  break_address_low;
  logic        break_enable_bit;
  logic        break_active_flag;
  logic        wait_exit_by_break_flag;
  logic        clear_flag_enable_bit;
  logic        operand_pending;
  logic        addr_match;
  logic        opcode_hit;
  logic        operand_hit;
  logic        sw_break;
  logic        wr_ctrl;
  logic        next_request;
  logic        latch_pending;
  logic        normal_entry;
  logic        forced_entry;
  mon_state_t  mon_state;
  logic [11:0] bit_timer;
  logic [3:0]  bit_count;
  logic [3:0]  byte_count;
  logic [7:0]  shift_reg;

  assign wr_ctrl     = reg_req.wr && (reg_req.addr == OFS_STATUS_CONTROL);
  assign addr_match  = break_enable_bit && cpu_bus.addr_valid &&
                       (cpu_bus.addr == {break_address_high, break_address_low});
  assign opcode_hit  = addr_match && cpu_bus.opcode_fetch && !break_state;
  assign operand_hit = addr_match && !cpu_bus.opcode_fetch && !break_state;
  assign sw_break    = wr_ctrl && reg_req.wdata[ACTIVE_BIT] && !break_state;
  assign next_request = opcode_hit || sw_break ||
                        (operand_pending && cpu_bus.instr_done);

  // Break address bytes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      break_address_high <= RESET_BYTE;
      break_address_low  <= RESET_BYTE;
    end else if (reg_req.wr) begin
      if (reg_req.addr == OFS_ADDRESS_HIGH) begin
        break_address_high <= reg_req.wdata;
      end
      if (reg_req.addr == OFS_ADDRESS_LOW) begin
        break_address_low <= reg_req.wdata;
      end
    end
  end

  // Enable and active flag; hardware set wins over software clear
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      break_enable_bit  <= 1'b0;
      break_active_flag <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        break_enable_bit <= reg_req.wdata[ENABLE_BIT];
      end
      if (opcode_hit || operand_hit || sw_break) begin
        break_active_flag <= 1'b1;
      end else if (wr_ctrl && !reg_req.wdata[ACTIVE_BIT]) begin
        break_active_flag <= 1'b0;
      end
    end
  end

  // Operand match waits for the instruction to finish
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      operand_pending <= 1'b0;
    end else if (operand_hit) begin
      operand_pending <= 1'b1;
    end else if (cpu_bus.instr_done) begin
      operand_pending <= 1'b0;
    end
  end

  // Break request and handler state
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      breakpoint_request <= 1'b0;
      opcode_suppress    <= 1'b0;
      break_state        <= 1'b0;
    end else begin
      breakpoint_request <= next_request;
      if (next_request) begin
        break_state     <= 1'b1;
        opcode_suppress <= opcode_hit;
      end else if (cpu_bus.rti_done) begin
        break_state     <= 1'b0;
        opcode_suppress <= 1'b0;
      end
    end
  end

  // Wait exit flag, cleared when the handler returns
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_exit_by_break_flag <= 1'b0;
    end else if (next_request && cpu_bus.in_wait) begin
      wait_exit_by_break_flag <= 1'b1;
    end else if (cpu_bus.rti_done) begin
      wait_exit_by_break_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clear_flag_enable_bit <= 1'b0;
    end else if (reg_req.wr && reg_req.addr == OFS_FLAG_CLEAR_CONTROL) begin
      clear_flag_enable_bit <= reg_req.wdata[CLEAR_ENABLE_BIT];
    end
  end

  assign status_clear_allowed = !break_state || clear_flag_enable_bit;
  assign break_vector = monitor_mode ? MONITOR_BREAK_VECTOR : USER_BREAK_VECTOR;

  // Register read port
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        OFS_STATUS_CONTROL:     reg_rdata <= {break_enable_bit, break_active_flag, 6'h00};
        OFS_ADDRESS_HIGH:       reg_rdata <= break_address_high;
        OFS_ADDRESS_LOW:        reg_rdata <= break_address_low;
        OFS_WAIT_EXIT_STATUS:   reg_rdata <= {6'h00, wait_exit_by_break_flag, 1'b0};
        OFS_FLAG_CLEAR_CONTROL: reg_rdata <= {clear_flag_enable_bit, 7'h00};
        default:                reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // Monitor entry conditions
  assign normal_entry = entry_pins.test_high_voltage && monitor_serial_pin_in &&
                        !entry_pins.serial_select_pin && entry_pins.mode_select_pin_a &&
                        !entry_pins.mode_select_pin_b;
  assign forced_entry = !entry_pins.test_high_voltage && monitor_serial_pin_in &&
                        !entry_pins.serial_select_pin &&
                        (entry_pins.reset_vector_high == ERASED_BYTE) &&
                        (entry_pins.reset_vector_low == ERASED_BYTE);

  // Mode captured in the first cycle after reset release
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      latch_pending  <= 1'b1;
      monitor_mode   <= 1'b0;
      forced_monitor <= 1'b0;
    end else if (latch_pending) begin
      latch_pending  <= 1'b0;
      monitor_mode   <= entry_pins.power_on_reset && (normal_entry || forced_entry);
      forced_monitor <= entry_pins.power_on_reset && !normal_entry && forced_entry;
    end
  end

  // Serial receive of security bytes, then break transmit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mon_state           <= MON_OFF;
      bit_timer           <= 12'h000;
      bit_count           <= 4'h0;
      byte_count          <= 4'h0;
      shift_reg           <= 8'h00;
      security_byte       <= 8'h00;
      security_byte_valid <= 1'b0;
    end else begin
      security_byte_valid <= 1'b0;
      bit_timer           <= bit_timer + 12'h001;
      case (mon_state)
        MON_OFF: begin
          if (latch_pending && entry_pins.power_on_reset && (normal_entry || forced_entry)) begin
            mon_state <= MON_IDLE;
          end
        end
        MON_IDLE: begin
          bit_timer <= 12'h000;
          if (!monitor_serial_pin_in) begin
            mon_state <= MON_START;
          end
        end
        MON_START: begin
          if (bit_timer == HALF_BIT_CYCLES - 12'h001) begin
            bit_timer <= 12'h000;
            bit_count <= 4'h0;
            mon_state <= monitor_serial_pin_in ? MON_IDLE : MON_BITS;
          end
        end
        MON_BITS: begin
          if (bit_timer == BIT_CYCLES - 12'h001) begin
            bit_timer <= 12'h000;
            shift_reg <= {monitor_serial_pin_in, shift_reg[7:1]};
            bit_count <= bit_count + 4'h1;
            if (bit_count == DATA_BITS - 4'h1) begin
              mon_state <= MON_STOP;
            end
          end
        end
        MON_STOP: begin
          if (bit_timer == BIT_CYCLES - 12'h001) begin
            bit_timer           <= 12'h000;
            security_byte       <= shift_reg;
            security_byte_valid <= 1'b1;
            byte_count          <= byte_count + 4'h1;
            mon_state <= (byte_count == SECURITY_BYTES - 4'h1) ? MON_BREAK : MON_IDLE;
          end
        end
        MON_BREAK: begin
          if (bit_timer == BREAK_CYCLES - 12'h001) begin
            mon_state <= MON_READY;
          end
        end
        MON_READY: begin
          bit_timer <= 12'h000;
        end
        default: begin
          mon_state <= MON_OFF;
        end
      endcase
    end
  end

  assign monitor_serial_pin_out = 1'b0;
  assign monitor_serial_pin_oe  = (mon_state == MON_BREAK);
  assign monitor_ready          = (mon_state == MON_READY);

  // Checks
  logic [11:0] low_count;
  always_ff @(posedge clk) begin
    if (sys_rst || !monitor_serial_pin_oe) begin
      low_count <= 12'h000;
    end else begin
      low_count <= low_count + 12'h001;
    end
  end

  sequence operand_seen;
    operand_hit;
  endsequence
  sequence instr_finishes;
    !next_request ##1 cpu_bus.instr_done;
  endsequence

  match_request_a: assert property (@(posedge clk) disable iff (sys_rst)
    opcode_hit |=> breakpoint_request && opcode_suppress && break_state)
    else $error("opcode match gave no break");
  enable_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
    wr_ctrl && !reg_req.wdata[ENABLE_BIT] |=> !break_enable_bit && !addr_match)
    else $error("enable bit not cleared");
  active_set_a: assert property (@(posedge clk) disable iff (sys_rst)
    (opcode_hit || operand_hit) |=> break_active_flag)
    else $error("active flag not set on match");
  sw_break_a: assert property (@(posedge clk) disable iff (sys_rst)
    sw_break |=> breakpoint_request && break_active_flag)
    else $error("software break missing");
  addr_reset_a: assert property (@(posedge clk)
    sys_rst |=> (break_address_high == 8'h00) && (break_address_low == 8'h00))
    else $error("break address not reset");
  wait_exit_a: assert property (@(posedge clk) disable iff (sys_rst)
    next_request && cpu_bus.in_wait |=> wait_exit_by_break_flag && break_state)
    else $error("wait exit flag not set");
  clear_policy_a: assert property (@(posedge clk) disable iff (sys_rst)
    break_state && !clear_flag_enable_bit |-> !status_clear_allowed)
    else $error("status clear allowed in break");
  idle_bus_a: assert property (@(posedge clk) disable iff (sys_rst)
    !cpu_bus.addr_valid && !sw_break && !operand_pending |=> !breakpoint_request)
    else $error("break without moving address bus");
  mode_hold_a: assert property (@(posedge clk) disable iff (sys_rst)
    !latch_pending && !$past(latch_pending) |-> $stable(monitor_mode))
    else $error("monitor mode changed after latch");
  operand_wait_a: assert property (@(posedge clk) disable iff (sys_rst)
    operand_seen ##1 instr_finishes |=> breakpoint_request)
    else $error("operand break not after instruction");
  break_length_a: assert property (@(posedge clk) disable iff (sys_rst)
    $fell(monitor_serial_pin_oe) |-> $past(low_count) == BREAK_CYCLES - 12'h001)
    else $error("break length wrong");
  vector_page_a: assert property (@(posedge clk) disable iff (sys_rst)
    breakpoint_request && monitor_mode |-> break_vector[15:8] == 8'hfe)
    else $error("monitor break vector wrong");
endmodule
`default_nettype wire

// ---- break_and_monitor_entry_tb.sv ----
`timescale 1ns/10ps
`default_nettype none
module break_and_monitor_entry_tb;
  import brk_mon_pkg::*;
  logic        clk;
  logic        sys_rst;
  reg_req_t    req;
  cpu_bus_t    cpu;
  entry_pins_t pins;
  logic [7:0]  rdata;
  logic [7:0]  sec_byte;
  logic [15:0] vector;
  logic        brk_req, suppress, brk_state, clr_ok, mon_mode, forced;
  logic        byte_valid, ready, pin_out, pin_oe, host_low;
  wire logic   line_level;
  logic [7:0]  got [8];
  int          mismatches = 0;
  int          checked = 0;
  int          req_cnt = 0;
  int          oe_cnt = 0;
  int          n_bytes = 0;

  // Wired-OR line with pullup
  assign line_level = !((pin_oe && !pin_out) || host_low);

  break_and_monitor_entry DUT (.clk(clk), .sys_rst(sys_rst), .reg_req(req),
    .reg_rdata(rdata), .cpu_bus(cpu), .breakpoint_request(brk_req),
    .opcode_suppress(suppress), .break_state(brk_state), .break_vector(vector),
    .status_clear_allowed(clr_ok), .entry_pins(pins),
    .monitor_serial_pin_in(line_level), .monitor_serial_pin_out(pin_out),
    .monitor_serial_pin_oe(pin_oe), .monitor_mode(mon_mode),
    .forced_monitor(forced), .security_byte(sec_byte),
    .security_byte_valid(byte_valid), .monitor_ready(ready));
  host_link host (.clk(clk), .drive_low(host_low));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  always @(posedge clk) begin
    if (brk_req === 1'b1) req_cnt++;
    if (pin_oe === 1'b1) oe_cnt++;
    if (byte_valid === 1'b1 && n_bytes < 8) begin
      got[n_bytes] = sec_byte;
      n_bytes++;
    end
  end

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(16'(rdata), 16'(e));
  endtask

  task automatic cpu_at(input logic [15:0] a, input logic v, input logic op, input logic w);
    @(posedge clk);
    cpu.addr <= a;
    cpu.addr_valid <= v;
    cpu.opcode_fetch <= op;
    cpu.in_wait <= w;
  endtask

  task automatic rti;
    @(posedge clk);
    cpu.rti_done <= 1'b1;
    @(posedge clk);
    cpu.rti_done <= 1'b0;
    @(posedge clk);
  endtask

  task automatic do_reset(input entry_pins_t p, input logic m, input logic f);
    @(posedge clk);
    sys_rst <= 1'b1;
    pins <= p;
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk);
    pins <= '0;
    repeat (2) @(posedge clk);
    #1 chk(16'(mon_mode), 16'(m));
    chk(16'(forced), 16'(f));
    $display("reset entry test done");
  endtask

  initial begin
    sys_rst = 1'b1;
    req = '0;
    cpu = '0;
    pins = '0;
    do_reset('{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00}, 1'b1, 1'b0);
    chk(vector, MONITOR_BREAK_VECTOR);
    for (int i = 0; i < 6; i++) rd_chk(3'(i), 8'h00);
    $display("register reset test done");
    wr(OFS_ADDRESS_HIGH, 8'h12);
    wr(OFS_ADDRESS_LOW, 8'h34);
    rd_chk(OFS_ADDRESS_HIGH, 8'h12);
    rd_chk(OFS_ADDRESS_LOW, 8'h34);
    cpu_at(16'h1234, 1'b1, 1'b1, 1'b0);
    cpu_at(16'h0000, 1'b0, 1'b0, 1'b0);
    wr(OFS_STATUS_CONTROL, 8'h80);
    rd_chk(OFS_STATUS_CONTROL, 8'h80);
    cpu_at(16'h1234, 1'b0, 1'b1, 1'b1);
    cpu_at(16'h1235, 1'b1, 1'b1, 1'b0);
    cpu_at(16'h0000, 1'b0, 1'b0, 1'b0);
    repeat (2) @(posedge clk);
    #1 chk(16'(req_cnt), 16'h0);
    $display("no-break test done");
    cpu_at(16'h1234, 1'b1, 1'b1, 1'b0);
    @(posedge clk);
    #1 chk(16'(brk_req), 16'h1);
    chk(16'(suppress), 16'h1);
    cpu_at(16'h0000, 1'b0, 1'b0, 1'b0);
    #1 chk(16'(brk_state), 16'h1);
    chk(16'(clr_ok), 16'h0);
    rd_chk(OFS_STATUS_CONTROL, 8'hc0);
    wr(OFS_FLAG_CLEAR_CONTROL, 8'h80);
    #1 chk(16'(clr_ok), 16'h1);
    rd_chk(OFS_FLAG_CLEAR_CONTROL, 8'h80);
    wr(OFS_FLAG_CLEAR_CONTROL, 8'h00);
    wr(OFS_STATUS_CONTROL, 8'h80);
    rd_chk(OFS_STATUS_CONTROL, 8'h80);
    rti();
    #1 chk(16'(brk_state), 16'h0);
    chk(16'(suppress), 16'h0);
    $display("opcode break test done");
    cpu_at(16'h1234, 1'b1, 1'b0, 1'b0);
    cpu_at(16'h0000, 1'b0, 1'b0, 1'b0);
    #1 chk(16'(brk_req), 16'h0);
    @(posedge clk);
    cpu.instr_done <= 1'b1;
    @(posedge clk);
    cpu.instr_done <= 1'b0;
    #1 chk(16'(brk_req), 16'h1);
    chk(16'(suppress), 16'h0);
    wr(OFS_STATUS_CONTROL, 8'h80);
    rti();
    wr(OFS_STATUS_CONTROL, 8'hc0);
    #1 chk(16'(brk_req), 16'h1);
    wr(OFS_STATUS_CONTROL, 8'h80);
    rti();
    chk(16'(req_cnt), 16'h3);
    cpu_at(16'h0000, 1'b0, 1'b0, 1'b1);
    wr(OFS_STATUS_CONTROL, 8'hc0);
    rd_chk(OFS_WAIT_EXIT_STATUS, 8'h02);
    wr(OFS_STATUS_CONTROL, 8'h80);
    rti();
    rd_chk(OFS_WAIT_EXIT_STATUS, 8'h00);
    cpu_at(16'h0000, 1'b0, 1'b0, 1'b0);
    wr(OFS_STATUS_CONTROL, 8'h00);
    rd_chk(OFS_STATUS_CONTROL, 8'h00);
    $display("operand and software break test done");
    for (int i = 0; i < 7; i++) host.send_byte(8'ha5 ^ 8'(i * 17));
    chk(16'(oe_cnt), 16'h0);
    host.send_byte(8'ha5 ^ 8'(7 * 17));
    for (int i = 0; i < 6000 && ready !== 1'b1; i++) @(posedge clk);
    #1 chk(16'(ready), 16'h1);
    if (ready !== 1'b1) complete_run();
    chk(16'(oe_cnt), 16'(BREAK_CYCLES));
    chk(16'(n_bytes), 16'h8);
    chk(16'(pin_out), 16'h0);
    for (int i = 0; i < 8; i++) chk(16'(got[i]), 16'(8'ha5 ^ 8'(i * 17)));
    $display("monitor entry test done");
    do_reset('{1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'hff, 8'hff}, 1'b1, 1'b1);
    do_reset('{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 8'h00, 8'h00}, 1'b0, 1'b0);
    chk(vector, USER_BREAK_VECTOR);
    do_reset('{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 8'hff, 8'hfe}, 1'b0, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire

// ---- brk_mon_pkg.sv ----
// Operation
// - Full 16-bit address match requests a break only while enabled.
// - Enable bit is bit 7 of control; writing zero clears; reset clears.
// - Enabled address match sets the active flag; reset clears it.
// - Software writing one to the active flag raises a break.
// - High and low break address bytes, both cleared by reset.
// - Status flag reads one when a break ended wait mode.
// - In break state, status clears need the clear-flag enable bit set.
// - Unit stays enabled in wait and stop; idle address bus yields no break.
// - Monitor entry without test voltage when both reset vector bytes are erased.
// - Monitor mode entered only from power-on reset; host supplies clock.
// - Mode captured at reset release; pins afterwards no longer matter.
// - Monitor serial bit period is 256 bus clock cycles.
// - One wired-OR serial pin; device only pulls low or releases.
// - Non-return-to-zero framing at equal baud rate on both sides.
// - Wait for eight security bytes, then send ten zero bits.
// - Break forces software interrupt, vectoring via user or monitor page.
// - Opcode break suppresses the instruction; operand break lets it finish.
package brk_mon_pkg;
  localparam logic [2:0]  OFS_STATUS_CONTROL     = 3'h0;
  localparam logic [2:0]  OFS_ADDRESS_HIGH       = 3'h1;
  localparam logic [2:0]  OFS_ADDRESS_LOW        = 3'h2;
  localparam logic [2:0]  OFS_WAIT_EXIT_STATUS   = 3'h3;
  localparam logic [2:0]  OFS_FLAG_CLEAR_CONTROL = 3'h4;
  localparam int          ENABLE_BIT             = 7;
  localparam int          ACTIVE_BIT             = 6;
  localparam int          WAIT_EXIT_BIT          = 1;
  localparam int          CLEAR_ENABLE_BIT       = 7;
  localparam logic [7:0]  RESET_BYTE             = 8'h00;
  localparam logic [7:0]  ERASED_BYTE            = 8'hff;
  localparam logic [15:0] USER_BREAK_VECTOR      = 16'hfffc;
  localparam logic [15:0] MONITOR_BREAK_VECTOR   = 16'hfefc;
  localparam logic [11:0] BIT_CYCLES             = 12'h100;
  localparam logic [11:0] HALF_BIT_CYCLES        = 12'h080;
  localparam logic [3:0]  SECURITY_BYTES         = 4'h8;
  localparam logic [3:0]  DATA_BITS              = 4'h8;
  localparam logic [11:0] BREAK_CYCLES           = 12'ha00;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic [15:0] addr;
    logic        addr_valid;
    logic        opcode_fetch;
    logic        instr_done;
    logic        rti_done;
    logic        in_wait;
  } cpu_bus_t;

  typedef struct packed {
    logic       power_on_reset;
    logic       test_high_voltage;
    logic       serial_select_pin;
    logic       mode_select_pin_a;
    logic       mode_select_pin_b;
    logic [7:0] reset_vector_high;
    logic [7:0] reset_vector_low;
  } entry_pins_t;

  typedef enum logic [2:0] {
    MON_OFF   = 3'b000,
    MON_IDLE  = 3'b001,
    MON_START = 3'b010,
    MON_BITS  = 3'b011,
    MON_STOP  = 3'b100,
    MON_BREAK = 3'b101,
    MON_READY = 3'b110
  } mon_state_t;
endpackage

// ---- host_link.sv ----
`timescale 1ns/10ps
`default_nettype none
module host_link
  import brk_mon_pkg::*;
(
  input  wire logic clk,      // Bus clock
  output logic      drive_low // Host pulls shared line low
);
  initial drive_low = 1'b0;
  // Start, data LSB first, stop; line released after the frame
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      drive_low <= !frame[i];
      repeat (int'(BIT_CYCLES) - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire
